// ===== bench/sciqs_far_tx.sv
// far-end serial station model handing whole characters to the block
module sciqs_far_tx (
  input wire logic clk_sys_i,        // module clock
  input wire logic go_i,             // start one character
  input wire logic [8:0] d_i,        // character value
  input wire logic [2:0] f_i,        // noise, bad stop, bad parity
  output sciqs_pkg::sciqs_rx_s rx_o, // delivered character
  output logic pin_o                 // receive line level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  always @(posedge clk_sys_i) begin
    if (go_i) begin
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
    if (!go_i && cnt == 3'h1) begin
      rx_o <= '{1'b1, d_i, f_i[2], !f_i[1], f_i[0]};
    end else begin
      // fields off the done cycle toggle, so stale data never looks valid
      rx_o <= {1'b0, ~rx_o[11:0]};
    end
  end
  // mark between frames lets break detection rearm
  assign pin_o = (cnt == 3'h0);
endmodule

// ===== bench/test_sciqs_core.sv
// self-checking bench for the receive status and data block
module test_sciqs_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DT = sciqs_pkg::DATA_OFS;
  localparam logic [7:0] C2 = sciqs_pkg::CTRL2_OFS;
  localparam logic [7:0] C3 = sciqs_pkg::CTRL3_OFS;
  localparam logic [7:0] S1 = sciqs_pkg::STAT1_OFS;
  localparam logic [7:0] S2 = sciqs_pkg::STAT2_OFS;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  sciqs_pkg::sciqs_bus_s bus = '0;
  sciqs_pkg::sciqs_rx_s rx;
  logic [7:0] rdata, txd, d, b;
  logic pin, ninth, tst, tirq, rirq, eirq, rip;
  logic c9 = 1'b0, busy = 1'b0, go = 1'b0, rx_en = 1'b1;
  logic [6:0] pls = '0;
  logic [8:0] gd = '0;
  logic [2:0] gf = '0;
  int error_cnt = 0, checks_done = 0, seed = 78348, cyc = 0;

  sciqs_core DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .rx_i(rx), .char9_i(c9), .rx_enable_i(rx_en), .rx_pin_i(pin), .break_i(pls[0]),
    .idle_i(pls[1]), .first_slot_zero_i(pls[2]), .false_start_i(pls[3]),
    .tx_load_i(pls[4]), .tx_busy_i(busy), .tx_queue_i(pls[5]), .tx_tick_i(pls[6]),
    .tx_start_o(tst), .tx_data_o(txd), .tx_ninth_o(ninth), .tx_irq_o(tirq),
    .rx_irq_o(rirq), .err_irq_o(eirq), .rx_in_progress_o(rip));
  sciqs_far_tx far (.clk_sys_i(clk_sys_i), .go_i(go), .d_i(gd), .f_i(gf), .rx_o(rx),
    .pin_o(pin));

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic err_exp(input logic [3:0] f, input logic [3:0] ie);
    return |(f & ie);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one register access; d holds read data once the answer has landed
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] v);
    @(posedge clk_sys_i);
    bus <= '{a, !w, w, v};
    @(posedge clk_sys_i);
    bus <= '{a, 1'b0, 1'b0, v};
    #1 d = rdata;
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys_i);
    pls[i] <= 1'b1;
    @(posedge clk_sys_i);
    pls[i] <= 1'b0;
    #1;
  endtask
  task automatic send(input logic [8:0] v, input logic [2:0] f);
    @(posedge clk_sys_i);
    gd <= v;
    gf <= f;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    acc(S1, 0, 0);
    chk(d, 8'hc0);
    acc(S2, 0, 0);
    chk(d, 8'h00);
    acc(C3, 0, 0);
    chk(d & 8'h0f, 8'h00);
    acc(8'h1f, 0, 0);
    chk(d, 8'h00);
    pulse(2);
    chk(rip, 1'b1);
    pulse(1);
    chk(rip, 1'b0);
    pulse(2);
    pulse(3);
    chk(rip, 1'b0);
    acc(S1, 0, 0);
    chk(d, 8'hc0);
    acc(C2, 1, 8'h20);
    b = $random(seed);
    send({1'b0, b}, 3'h0);
    chk(rirq, 1'b1);
    acc(C3, 0, 0);
    chk(d & 8'h80, b & 8'h80);
    acc(S1, 0, 0);
    chk(d, 8'he0);
    acc(DT, 0, 0);
    chk(d, b);
    pulse(1);
    chk(rirq, 1'b0);
    acc(S1, 0, 0);
    chk(d, 8'hd0);
    acc(DT, 0, 0);
    pulse(1);
    acc(S1, 0, 0);
    chk(d, 8'hc0);
    for (int i = 0; i < 4; i++) begin
      b = $random(seed);
      acc(C3, 1, 8'h01 << i);
      send({1'b0, b}, 3'h7);
      chk(eirq, err_exp(4'h7, 4'h1 << i));
      acc(S1, 0, 0);
      chk(d, 8'he7);
      acc(DT, 0, 0);
      chk(d, b);
    end
    acc(S1, 0, 0);
    chk(d, 8'hc0);
    for (int k = 0; k < 2; k++) begin
      b = $random(seed);
      send({1'b0, b}, 3'h0);
      if (k == 0) begin
        acc(S1, 0, 0);
      end
      send({1'b0, ~b}, 3'h0);
      chk(eirq, 1'b1);
      acc(DT, 0, 0);
      chk(d, b);
      // re-read after the data read exposes an overrun met mid-sequence
      acc(S1, 0, 0);
      chk(d, (k == 0) ? 8'hc8 : 8'he8);
      acc(DT, 0, 0);
    end
    acc(S1, 0, 0);
    chk(d, 8'hc0);
    // poll in-progress, then cycle the receiver: idle must wait for a new character
    acc(S2, 0, 0);
    chk(d, 8'h00);
    rx_en <= 1'b0;
    pulse(1);
    rx_en <= 1'b1;
    pulse(1);
    acc(S1, 0, 0);
    chk(d, 8'hc0);
    c9 <= 1'b1;
    send({1'b1, b}, 3'h0);
    acc(C3, 0, 0);
    chk(d & 8'h80, 8'h80);
    pulse(0);
    acc(C3, 0, 0);
    chk(d & 8'h80, 8'h00);
    acc(S2, 0, 0);
    chk(d, 8'h02);
    acc(S1, 0, 0);
    chk(d, 8'he2);
    acc(DT, 0, 0);
    chk(d, 8'h00);
    acc(S2, 0, 0);
    chk(d, 8'h00);
    acc(C2, 1, 8'hc0);
    chk(tirq, 1'b1);
    acc(S1, 0, 0);
    b = $random(seed);
    acc(DT, 1, b);
    chk(txd, b);
    acc(C3, 1, 8'h48);
    chk(ninth, 1'b1);
    acc(S1, 0, 0);
    chk(d, 8'h40);
    busy <= 1'b1;
    pulse(5);
    chk(tst, 1'b0);
    acc(S1, 0, 0);
    chk(d, 8'h00);
    chk(tirq, 1'b0);
    pulse(6);
    chk(tst, 1'b1);
    pulse(4);
    chk(tst, 1'b0);
    acc(S1, 0, 0);
    chk(d, 8'h80);
    busy <= 1'b0;
    acc(S1, 0, 0);
    chk(d, 8'hc0);
    final_report();
  end
endmodule

// ===== hdl/sciqs_core.sv
// receive status, fault flags, interrupt requests and data buffer
//
// Overview of operation
// - overrun drives the error request only while overrun_irq_enable is set.
// - noise and framing enables reset low and gate their flags' error requests.
// - parity_fault_irq_enable resets low; when set the parity flag requests.
// - empty flag sets on buffer-to-shifter move, reset sets; status read then write clears.
// - complete flag set while empty and idle; reset sets; queueing clears it.
// - a queued transmission starts within one and a half transmitter clocks.
// - full flag sets on character transfer; status read then data read clears.
// - idle flag sets on idle line; idle enable requests; read pair clears.
// - idle may set only after a received character since enable or clear.
// - overrun sets when a character lands on a full buffer; new byte dropped.
// - data read clears overrun only if the prior status read saw it.
// - noise flag sets on line noise; gated by its enable; read pair clears.
// - framing flag sets on a zero stop bit; gated; read pair clears.
// - parity flag sets on a failed parity check; gated; read pair clears.
// - break sets break, framing and full flags; clears ninth bit in 9-bit mode.
// - break flag clears by second status read then data read; rearms on ones.
// - in-progress flag sets on zero in first slot; clears on false start or idle.
// - ninth received bit captured with the byte; mirrors bit seven in 8-bit mode.
module sciqs_core (
  input wire logic clk_sys_i,              // module clock
  input wire logic rst_i,                  // sync reset
  input wire sciqs_pkg::sciqs_bus_s bus_i, // cpu access
  output logic [7:0] rdata_o,              // read data, valid after rd
  input wire sciqs_pkg::sciqs_rx_s rx_i,   // character from the shifter
  input wire logic char9_i,                // 9-bit characters
  input wire logic rx_enable_i,            // receiver enabled
  input wire logic rx_pin_i,               // rx_input_pin level
  input wire logic break_i,                // break character seen
  input wire logic idle_i,                 // idle character seen
  input wire logic first_slot_zero_i,      // zero in first_sample_slot
  input wire logic false_start_i,          // false start bit
  input wire logic tx_load_i,              // buffer moved to tx shifter
  input wire logic tx_busy_i,              // data, preamble or break on line
  input wire logic tx_queue_i,             // something queued to send
  input wire logic tx_tick_i,              // transmitter clock tick
  output logic tx_start_o,                 // start transmission pulse
  output logic [7:0] tx_data_o,            // byte to transmit
  output logic tx_ninth_o,                 // ninth bit to transmit
  output logic tx_irq_o,                   // transmitter request
  output logic rx_irq_o,                   // receiver request
  output logic err_irq_o,                  // error request
  output logic rx_in_progress_o            // reception underway
);
  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic stat_rd;
  logic stat2_rd;
  logic data_rd;
  logic data_wr;
  logic ctrl2_wr;
  logic ctrl3_wr;

  always_comb begin
    stat_rd = 1'b0;
    stat2_rd = 1'b0;
    data_rd = 1'b0;
    data_wr = 1'b0;
    ctrl2_wr = 1'b0;
    ctrl3_wr = 1'b0;
    if (bus_i.addr == sciqs_pkg::DATA_OFS) begin
      data_rd = bus_i.rd;
      data_wr = bus_i.wr;
    end else if (bus_i.addr == sciqs_pkg::CTRL2_OFS) begin
      ctrl2_wr = bus_i.wr;
    end else if (bus_i.addr == sciqs_pkg::CTRL3_OFS) begin
      ctrl3_wr = bus_i.wr;
    end else if (bus_i.addr == sciqs_pkg::STAT1_OFS) begin
      stat_rd = bus_i.rd;
    end else if (bus_i.addr == sciqs_pkg::STAT2_OFS) begin
      stat2_rd = bus_i.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  logic [3:0] ie2;
  logic [3:0] ie3;
  logic [3:0] next_ie2;
  logic [3:0] next_ie3;

  always_comb begin
    next_ie2 = ie2;
    next_ie3 = ie3;
    if (ctrl2_wr) begin
      next_ie2 = bus_i.wdata[sciqs_pkg::C2_TXE_IE -: 4];
    end
    if (ctrl3_wr) begin
      next_ie3 = bus_i.wdata[sciqs_pkg::C3_OVR_IE:sciqs_pkg::C3_PAR_IE];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ie2 <= sciqs_pkg::CTRL_IE_RST;
      ie3 <= sciqs_pkg::CTRL_IE_RST;
    end else begin
      ie2 <= next_ie2;
      ie3 <= next_ie3;
    end
  end

  logic txe_ie;
  logic tc_ie;
  logic rxf_ie;
  logic idle_ie;
  assign txe_ie = ie2[3];
  assign tc_ie = ie2[2];
  assign rxf_ie = ie2[1];
  assign idle_ie = ie2[0];

  ////////////////////////////////////////////////////////////////////////
  // clearable flags
  logic accept;
  logic ovr;
  logic brk_hit;
  logic brk_rearm;
  logic next_brk_rearm;
  logic idle_allow;
  logic next_idle_allow;
  logic next_flag_idle;
  logic [sciqs_pkg::NFLAG-1:0] flag_set;
  logic [sciqs_pkg::NFLAG-1:0] flag_arm;
  logic [sciqs_pkg::NFLAG-1:0] flag_clr;
  logic [sciqs_pkg::NFLAG-1:0] flags;
  logic [sciqs_pkg::NFLAG-1:0] armed;

  assign accept = rx_i.done && !flags[sciqs_pkg::FI_RXF];
  assign ovr = rx_i.done && flags[sciqs_pkg::FI_RXF];
  // a break that stays on the line is reported once
  assign brk_hit = break_i && brk_rearm;

  always_comb begin
    flag_set[sciqs_pkg::FI_TXE] = tx_load_i;
    flag_set[sciqs_pkg::FI_RXF] = accept || brk_hit;
    flag_set[sciqs_pkg::FI_IDLE] = idle_i && idle_allow;
    flag_set[sciqs_pkg::FI_OVR] = ovr;
    flag_set[sciqs_pkg::FI_NOISE] = rx_i.done && rx_i.noise;
    flag_set[sciqs_pkg::FI_FRM] = (rx_i.done && !rx_i.stop_bit) || brk_hit;
    flag_set[sciqs_pkg::FI_PAR] = rx_i.done && rx_i.parity_bad;
    flag_set[sciqs_pkg::FI_BRK] = brk_hit;
    flag_arm = {sciqs_pkg::NFLAG{stat_rd}};
    flag_arm[sciqs_pkg::FI_BRK] = stat2_rd;
    flag_clr = {sciqs_pkg::NFLAG{data_rd}};
    flag_clr[sciqs_pkg::FI_TXE] = data_wr;
  end

  generate
    for (genvar i = 0; i < sciqs_pkg::NFLAG; i++) begin : g_flag
      sciqs_flag #(
        .RST_VAL(i == sciqs_pkg::FI_TXE ? sciqs_pkg::TXE_RST : sciqs_pkg::FLAG_RST)
      ) u_flag (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .set_i(flag_set[i]),
        .arm_i(flag_arm[i]),
        .clr_i(flag_clr[i]),
        .flag_o(flags[i]),
        .armed_o(armed[i])
      );
    end
  endgenerate

  always_comb begin
    next_brk_rearm = brk_rearm;
    if (rx_pin_i) begin
      next_brk_rearm = 1'b1;
    end else if (brk_hit) begin
      next_brk_rearm = 1'b0;
    end
    next_idle_allow = idle_allow;
    // cleared when the idle flag drops or the receiver is off
    if (!rx_enable_i || (flags[sciqs_pkg::FI_IDLE] && !next_flag_idle)) begin
      next_idle_allow = 1'b0;
    end
    if (rx_enable_i && accept) begin
      next_idle_allow = 1'b1;
    end
  end

  assign next_flag_idle = flag_set[sciqs_pkg::FI_IDLE] ||
    !(flag_clr[sciqs_pkg::FI_IDLE] && armed[sciqs_pkg::FI_IDLE]);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      brk_rearm <= 1'b1;
      idle_allow <= 1'b0;
    end else begin
      brk_rearm <= next_brk_rearm;
      idle_allow <= next_idle_allow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit complete and reception in progress
  logic tc;
  logic next_tc;
  logic next_rpf;

  always_comb begin
    next_tc = tc;
    if (tx_queue_i) begin
      next_tc = 1'b0;
    end else if (flags[sciqs_pkg::FI_TXE] && !tx_busy_i) begin
      next_tc = 1'b1;
    end
    next_rpf = rx_in_progress_o;
    if (first_slot_zero_i) begin
      next_rpf = 1'b1;
    end else if (false_start_i || idle_i) begin
      next_rpf = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tc <= sciqs_pkg::TC_RST;
      rx_in_progress_o <= 1'b0;
    end else begin
      tc <= next_tc;
      rx_in_progress_o <= next_rpf;
    end
  end

  sciqs_launch u_launch (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .queue_i(tx_queue_i),
    .tick_i(tx_tick_i),
    .start_o(tx_start_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // data buffers, untouched by reset
  logic [7:0] rx_buf;
  logic r8;
  logic [7:0] next_rx_buf;
  logic next_r8;
  logic [7:0] next_tx_buf;
  logic next_t8;

  always_comb begin
    next_rx_buf = rx_buf;
    next_r8 = r8;
    next_tx_buf = tx_data_o;
    next_t8 = tx_ninth_o;
    if (brk_hit) begin
      next_rx_buf = 8'h00;
      if (char9_i) begin
        next_r8 = 1'b0;
      end
    end else if (accept) begin
      next_rx_buf = rx_i.data[7:0];
      next_r8 = char9_i ? rx_i.data[8] : rx_i.data[7];
    end
    if (data_wr) begin
      next_tx_buf = bus_i.wdata;
    end
    if (ctrl3_wr) begin
      next_t8 = bus_i.wdata[sciqs_pkg::C3_T8];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    rx_buf <= next_rx_buf;
    r8 <= next_r8;
    tx_data_o <= next_tx_buf;
    tx_ninth_o <= next_t8;
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux and requests
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = rdata_o;
    if (bus_i.rd) begin
      next_rdata = 8'h00;
      if (bus_i.addr == sciqs_pkg::DATA_OFS) begin
        next_rdata = rx_buf;
      end else if (bus_i.addr == sciqs_pkg::CTRL2_OFS) begin
        next_rdata = {ie2, 4'h0};
      end else if (bus_i.addr == sciqs_pkg::CTRL3_OFS) begin
        next_rdata = {r8, tx_ninth_o, 2'h0, ie3};
      end else if (bus_i.addr == sciqs_pkg::STAT1_OFS) begin
        next_rdata = {flags[sciqs_pkg::FI_TXE], tc, flags[sciqs_pkg::FI_RXF],
          flags[sciqs_pkg::FI_IDLE], flags[sciqs_pkg::FI_OVR],
          flags[sciqs_pkg::FI_NOISE], flags[sciqs_pkg::FI_FRM],
          flags[sciqs_pkg::FI_PAR]};
      end else if (bus_i.addr == sciqs_pkg::STAT2_OFS) begin
        next_rdata = {6'h00, flags[sciqs_pkg::FI_BRK], rx_in_progress_o};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // break has no request of its own
  assign err_irq_o = (flags[sciqs_pkg::FI_OVR] && ie3[sciqs_pkg::C3_OVR_IE]) ||
    (flags[sciqs_pkg::FI_NOISE] && ie3[sciqs_pkg::C3_NOISE_IE]) ||
    (flags[sciqs_pkg::FI_FRM] && ie3[sciqs_pkg::C3_FRM_IE]) ||
    (flags[sciqs_pkg::FI_PAR] && ie3[sciqs_pkg::C3_PAR_IE]);
  assign rx_irq_o = (flags[sciqs_pkg::FI_RXF] && rxf_ie) ||
    (flags[sciqs_pkg::FI_IDLE] && idle_ie);
  assign tx_irq_o = (flags[sciqs_pkg::FI_TXE] && txe_ie) || (tc && tc_ie);

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_tx_flags_reset: assert property ($fell(rst_i) |-> flags[0] && tc)
    else $error("empty and complete flags not set by reset");
  a_tx_empty_clear: assert property (
    data_wr && armed[sciqs_pkg::FI_TXE] && !tx_load_i |=> !flags[sciqs_pkg::FI_TXE])
    else $error("empty flag not cleared by status read then write");
  a_tc_queue: assert property (tx_queue_i |=> !tc)
    else $error("complete flag survived a queue");
  a_ovr_keeps_byte: assert property (
    ovr && !data_wr |=> $stable(rx_buf) && flags[sciqs_pkg::FI_OVR])
    else $error("overrun lost the buffered byte or the flag");
  a_ovr_late_set: assert property (
    flags[sciqs_pkg::FI_OVR] && data_rd && !armed[sciqs_pkg::FI_OVR]
    |=> flags[sciqs_pkg::FI_OVR])
    else $error("overrun cleared without a status read");
  a_idle_gate: assert property (
    $rose(flags[sciqs_pkg::FI_IDLE]) |-> $past(idle_allow))
    else $error("idle set without a character since enable or clear");
  a_break_sets: assert property (
    brk_hit |=> flags[sciqs_pkg::FI_BRK] && flags[sciqs_pkg::FI_FRM]
    && flags[sciqs_pkg::FI_RXF] && (r8 == 1'b0 || !$past(char9_i)))
    else $error("break did not set its flags");
  a_rpf_track: assert property (
    first_slot_zero_i |=> rx_in_progress_o)
    else $error("in-progress flag not set by a zero in the first slot");
  a_rpf_drop: assert property (
    (false_start_i || idle_i) && !first_slot_zero_i |=> !rx_in_progress_o)
    else $error("in-progress flag survived a false start or idle");
  a_parity_irq: assert property (
    flags[sciqs_pkg::FI_PAR] && ie3[sciqs_pkg::C3_PAR_IE] |-> err_irq_o)
    else $error("parity fault gave no request");
  a_ovr_irq_gate: assert property (
    !ie3[sciqs_pkg::C3_NOISE_IE] && !ie3[sciqs_pkg::C3_FRM_IE]
    && !ie3[sciqs_pkg::C3_PAR_IE] && !ie3[sciqs_pkg::C3_OVR_IE] |-> !err_irq_o)
    else $error("error request with all enables clear");
  a_ninth_mirror: assert property (
    accept && !brk_hit && !char9_i |=> r8 == rx_buf[7])
    else $error("ninth bit does not mirror bit seven");

  c_overrun: cover property (ovr ##[1:20] data_rd);
  c_break: cover property (brk_hit);
  c_idle: cover property (accept ##[1:200] flags[sciqs_pkg::FI_IDLE]);
endmodule

// ===== hdl/sciqs_flag.sv
// one clearable status flag with its read-then-access clearing sequence
module sciqs_flag #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_sys_i, // module clock
  input wire logic rst_i,     // sync reset
  input wire logic set_i,     // hardware event
  input wire logic arm_i,     // status register read
  input wire logic clr_i,     // data register access
  output logic flag_o,        // flag value
  output logic armed_o        // status read saw flag set
);
  logic next_flag;
  logic next_armed;

  always_comb begin
    next_armed = armed_o;
    if (arm_i) begin
      next_armed = flag_o;
    end
    next_flag = flag_o;
    if (clr_i && armed_o) begin
      next_flag = 1'b0;
      next_armed = 1'b0;
    end
    // an event in the clearing cycle is kept
    if (set_i) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      flag_o <= RST_VAL;
      armed_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
      armed_o <= next_armed;
    end
  end
endmodule

// ===== hdl/sciqs_launch.sv
// starts a queued transmission on the next transmitter clock tick
module sciqs_launch (
  input wire logic clk_sys_i, // module clock
  input wire logic rst_i,     // sync reset
  input wire logic queue_i,   // data, preamble or break queued
  input wire logic tick_i,    // transmitter clock tick
  output logic start_o        // one-cycle start pulse
);
  sciqs_pkg::sciqs_launch_e state;
  sciqs_pkg::sciqs_launch_e next_state;
  logic [1:0] ticks_seen;
  logic [1:0] next_ticks_seen;

  always_comb begin
    next_state = state;
    next_ticks_seen = ticks_seen;
    case (state)
      sciqs_pkg::LN_IDLE: begin
        next_ticks_seen = 2'h0;
        if (queue_i) begin
          next_state = sciqs_pkg::LN_WAIT;
        end
      end
      sciqs_pkg::LN_WAIT: begin
        // first tick after queueing is always inside the lag limit
        if (tick_i) begin
          next_state = sciqs_pkg::LN_FIRE;
          next_ticks_seen = ticks_seen + 2'h1;
        end
      end
      sciqs_pkg::LN_FIRE: begin
        next_state = queue_i ? sciqs_pkg::LN_WAIT : sciqs_pkg::LN_IDLE;
        next_ticks_seen = 2'h0;
      end
      default: begin
        next_state = sciqs_pkg::LN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= sciqs_pkg::LN_IDLE;
      ticks_seen <= 2'h0;
    end else begin
      state <= next_state;
      ticks_seen <= next_ticks_seen;
    end
  end

  assign start_o = (state == sciqs_pkg::LN_FIRE);

  a_start_lag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == sciqs_pkg::LN_WAIT && tick_i |=> start_o && ticks_seen <= 2'(sciqs_pkg::TX_LAG_TICKS))
    else $error("transmission start lagged the queue too long");
  c_launch: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    queue_i ##[1:40] start_o);
endmodule

// ===== pkg/sciqs_pkg.sv
// constants, carriers and state codes for the receive status and data block
package sciqs_pkg;
  // register offsets on the internal data bus
  localparam logic [7:0] DATA_OFS = 8'h18;
  localparam logic [7:0] CTRL2_OFS = 8'h19;
  localparam logic [7:0] CTRL3_OFS = 8'h1a;
  localparam logic [7:0] STAT1_OFS = 8'h1b;
  localparam logic [7:0] STAT2_OFS = 8'h1c;
  // second control register: interrupt enables
  localparam int unsigned C2_TXE_IE = 7;
  localparam int unsigned C2_TC_IE = 6;
  localparam int unsigned C2_RXF_IE = 5;
  localparam int unsigned C2_IDLE_IE = 4;
  // third control register
  localparam int unsigned C3_R8 = 7;
  localparam int unsigned C3_T8 = 6;
  localparam int unsigned C3_OVR_IE = 3;
  localparam int unsigned C3_NOISE_IE = 2;
  localparam int unsigned C3_FRM_IE = 1;
  localparam int unsigned C3_PAR_IE = 0;
  // primary status bit positions
  localparam int unsigned S1_TXE = 7;
  localparam int unsigned S1_TC = 6;
  localparam int unsigned S1_RXF = 5;
  localparam int unsigned S1_IDLE = 4;
  localparam int unsigned S1_OVR = 3;
  localparam int unsigned S1_NOISE = 2;
  localparam int unsigned S1_FRM = 1;
  localparam int unsigned S1_PAR = 0;
  // secondary status bit positions
  localparam int unsigned S2_BRK = 1;
  localparam int unsigned S2_RPF = 0;
  // clearable flag indices
  localparam int unsigned FI_TXE = 0;
  localparam int unsigned FI_RXF = 1;
  localparam int unsigned FI_IDLE = 2;
  localparam int unsigned FI_OVR = 3;
  localparam int unsigned FI_NOISE = 4;
  localparam int unsigned FI_FRM = 5;
  localparam int unsigned FI_PAR = 6;
  localparam int unsigned FI_BRK = 7;
  localparam int unsigned NFLAG = 8;
  // reset values
  localparam logic [3:0] CTRL_IE_RST = 4'h0;
  localparam logic TC_RST = 1'b1;
  localparam logic TXE_RST = 1'b1;
  localparam logic FLAG_RST = 1'b0;
  // longest start lag, in half transmitter clock periods (1.5 periods)
  localparam int unsigned TX_LAG_HALVES = 3;
  localparam int unsigned TX_LAG_TICKS = TX_LAG_HALVES / 2;

  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } sciqs_bus_s;

  typedef struct packed {
    logic done;
    logic [8:0] data;
    logic noise;
    logic stop_bit;
    logic parity_bad;
  } sciqs_rx_s;

  typedef enum logic [1:0] {
    LN_IDLE = 2'b00,
    LN_WAIT = 2'b01,
    LN_FIRE = 2'b11
  } sciqs_launch_e;
endpackage
